// file: testbench/acsl_axis_cmp_asserts.sv
/* Port checker for the comparator and soft-limit unit.
   Assumes it is bound to acsl_axis_cmp and sees only its ports. */
`timescale 1ns/10ps

module acsl_axis_cmp_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Motion core
  input wire logic const_speed_start,
  input wire logic stop_immediate,
  input wire logic stop_decelerate,
  input wire logic irq_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_STOP_ONE: assert property (!(stop_immediate && stop_decelerate))
    else $error("both stop requests high");
  AST_NOW_PULSE: assert property (stop_immediate |=> !stop_immediate)
    else $error("immediate stop longer than one cycle");
  AST_DEC_PULSE: assert property (stop_decelerate |=> !stop_decelerate)
    else $error("decelerating stop longer than one cycle");
  AST_CONST_NOW: assert property (const_speed_start && $past(const_speed_start)
    |-> !stop_decelerate) else $error("decelerating stop at constant speed");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");

  cover property (stop_immediate);
  cover property (stop_decelerate);
  cover property ($fell(irq_n));
endmodule // acsl_axis_cmp_asserts

bind acsl_axis_cmp acsl_axis_cmp_asserts acsl_axis_cmp_asserts_inst (.mclk(mclk), .reset(reset),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .const_speed_start(const_speed_start), .stop_immediate(stop_immediate),
  .stop_decelerate(stop_decelerate), .irq_n(irq_n));

// file: testbench/acsl_axis_cmp_tb.sv
/* Self-checking bench for the comparator and soft-limit unit.
   Assumes the package and design are compiled first; drives AXI4-Lite itself. */
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end

module acsl_axis_cmp_tb;
  logic mclk = 0;
  logic reset = 1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, cs = 0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [1:0] bresp, rresp, rsp;
  logic awready, wready, bvalid, arready, rvalid, stop_now, stop_dec, irq_n;
  logic p3o, p3e, p4o, p4e;
  acsl_pkg::acsl_step_t st1 = '0, st2 = '0;
  int n_mismatch = 0, cmp_count = 0, cyc = 0, n_now = 0, n_dec = 0, m;

  acsl_axis_cmp acsl_axis_cmp_inst (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .step_one(st1),
    .step_two(st2), .const_speed_start(cs), .stop_immediate(stop_now),
    .stop_decelerate(stop_dec), .irq_n(irq_n), .pin_three_in(1'b1), .pin_three_out(p3o),
    .pin_three_oe(p3e), .pin_four_in(1'b0), .pin_four_out(p4o), .pin_four_oe(p4e));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // Stop pulses are counted, since they stand one cycle only
  always @(posedge mclk) begin
    cyc++;
    if (stop_now) n_now++;
    if (stop_dec) n_dec++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Bus and count tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    `CHK(bresp, er)
  endtask

  task automatic rd_(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
    rd_(a);
    `CHK(rd & msk, e)
  endtask

  // One count pulse at a time, then time for flags to settle
  task automatic step(input logic s, input logic up, input int n = 1);
    repeat (n) begin
      @(posedge mclk);
      if (s) st2 <= {up, !up};
      else st1 <= {up, !up};
      @(posedge mclk);
      st1 <= '0;
      st2 <= '0;
    end
    repeat (3) @(posedge mclk);
  endtask

  task automatic give_verdict();
    $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 0;
    for (int i = 0; i < 13; i++) chk_rd(8'(i * 4), 32'hFFFF_FFF3, '0);
    chk_rd(8'h40, '1, '0);
    `CHK(rsp, acsl_pkg::RESP_SLVERR)
    wr(8'h40, 32'h1234_5678, acsl_pkg::RESP_SLVERR);
    wr(acsl_pkg::OFS_MSTS, '1);
    chk_rd(acsl_pkg::OFS_MSTS, 32'h0000_FFFF, '0);
    // Counter two sits at -1 so that signed and unsigned order differ
    wr(acsl_pkg::OFS_CNT1, 32'h0000_0005);
    wr(acsl_pkg::OFS_CNT2, 32'hFFFF_FFFF);
    for (int c = 0; c < 4; c++) begin
      for (int v = -1; v < 2; v++) begin
        wr(acsl_pkg::OFS_CMP1, 32'(5 + v));
        wr(acsl_pkg::OFS_CMP2, 32'(-1 + v));
        wr(acsl_pkg::OFS_ENV3, 32'(c << 12 | c << 14));
        m = (c == 1 && v == 0) || (c == 2 && v > 0) || (c == 3 && v < 0);
        chk_rd(acsl_pkg::OFS_MSTS, 32'h0000_0300, 32'(m * 3 << 8));
      end
    end
    wr(acsl_pkg::OFS_ENV3, 32'h0000_5000);
    wr(acsl_pkg::OFS_CMP1, 32'h0000_0064);
    wr(acsl_pkg::OFS_CNT1, 32'h0000_0062);
    wr(acsl_pkg::OFS_CMP2, 32'h0000_0007);
    wr(acsl_pkg::OFS_CNT2, 32'h0000_0006);
    wr(acsl_pkg::OFS_IRQEN, 32'h0000_00C0);
    rd_(acsl_pkg::OFS_EVF);
    rd_(acsl_pkg::OFS_ERF);
    `CHK(irq_n, 1'b1)
    step(0, 1, 2);
    step(1, 1);
    `CHK(irq_n, 1'b0)
    chk_rd(acsl_pkg::OFS_EVF, 32'h0000_00C0, 32'h0000_00C0);
    chk_rd(acsl_pkg::OFS_EVF, 32'h0000_00C0, '0);
    `CHK(irq_n, 1'b1)
    wr(acsl_pkg::OFS_IRQEN, '0);
    step(0, 1);
    step(0, 0);
    `CHK(irq_n, 1'b1)
    chk_rd(acsl_pkg::OFS_EVF, 32'h0000_00C0, 32'h0000_0040);
    wr(acsl_pkg::OFS_ENV2, 32'h8000_0000);
    step(0, 1);
    step(0, 0);
    chk_rd(acsl_pkg::OFS_EVF, 32'h0000_00C0, 32'h0000_0040);
    chk_rd(acsl_pkg::OFS_EVF, 32'h0000_00C0, 32'h0000_0040);
    wr(acsl_pkg::OFS_EVF, 32'h0000_0040);
    chk_rd(acsl_pkg::OFS_EVF, 32'h0000_00C0, '0);
    // Comparator one matches, comparator two is off
    wr(acsl_pkg::OFS_ENV3, 32'h0000_1000);
    wr(acsl_pkg::OFS_GPIO, 32'h0000_0001);
    chk_rd(acsl_pkg::OFS_GPIO, 32'h0000_000F, 32'h0000_0005);
    for (int p = 0; p < 4; p++) begin
      wr(acsl_pkg::OFS_ENV2, 32'(p << 6 | p << 8));
      repeat (2) @(posedge mclk);
      `CHK({p3e, p3o, p4e, p4o}, {p != 0, p == 1 || p == 3, p != 0, p == 2})
    end
    wr(acsl_pkg::OFS_ENV2, '0);
    // Counters brought into range before ring mode goes on
    wr(acsl_pkg::OFS_CMP1, 32'h0000_0004);
    wr(acsl_pkg::OFS_CMP2, 32'h0000_0004);
    wr(acsl_pkg::OFS_CNT1, 32'h0000_0004);
    wr(acsl_pkg::OFS_CNT2, '0);
    wr(acsl_pkg::OFS_ENV3, 32'h0000_0880);
    step(0, 1);
    step(1, 0);
    chk_rd(acsl_pkg::OFS_CNT1, '1, '0);
    chk_rd(acsl_pkg::OFS_CNT2, '1, 32'h0000_0004);
    step(0, 0);
    step(1, 1);
    chk_rd(acsl_pkg::OFS_CNT1, '1, 32'h0000_0004);
    chk_rd(acsl_pkg::OFS_CNT2, '1, '0);
    wr(acsl_pkg::OFS_CMP3, 32'h0000_0064);
    wr(acsl_pkg::OFS_CMP4, 32'hFFFF_FF9C);
    // Every limit mode, then decelerating mode at constant speed on counter two
    for (int i = 0; i < 5; i++) begin
      m = (i < 4) ? i : 3;
      cs <= (i == 4);
      wr(acsl_pkg::OFS_ENV3, 32'(m << 22 | (i == 4) << 24));
      for (int d = 0; d < 2; d++) begin
        wr((i == 4) ? acsl_pkg::OFS_CNT2 : acsl_pkg::OFS_CNT1, d ? 32'hFFFF_FF9C : 32'h0000_0064);
        rd_(acsl_pkg::OFS_EVF);
        rd_(acsl_pkg::OFS_ERF);
        n_now = 0;
        n_dec = 0;
        step(i == 4, !d);
        chk_rd(acsl_pkg::OFS_MSTS, 32'h0000_0C00, 32'(1 << (10 + d)));
        chk_rd(acsl_pkg::OFS_EVF, 32'h0000_C000, 32'(int'(m == 1) << (14 + d)));
        chk_rd(acsl_pkg::OFS_ERF, 32'h0000_0600, 32'(int'(m > 1) << (9 + d)));
        `CHK(n_now, int'(m == 2 || i == 4))
        `CHK(n_dec, int'(m == 3 && i < 4))
      end
    end
    give_verdict();
  end
endmodule // acsl_axis_cmp_tb

// file: verilog/acsl_axis_cmp.sv
/*
  Per-axis comparator and software-limit unit with its AXI4-Lite slave.
  Assumes synchronous inputs on mclk, one-cycle count pulses from the pulse
  logic, and a motion core that obeys the stop requests.
*/
`timescale 1ns/10ps

module acsl_axis_cmp (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic [acsl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [acsl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Count pulses for the two position counters
  input wire acsl_pkg::acsl_step_t step_one,
  input wire acsl_pkg::acsl_step_t step_two,
  // Motion core
  input wire logic const_speed_start,
  output logic stop_immediate,
  output logic stop_decelerate,
  output logic irq_n,
  // General pins three and four
  input wire logic pin_three_in,
  output logic pin_three_out,
  output logic pin_three_oe,
  input wire logic pin_four_in,
  output logic pin_four_out,
  output logic pin_four_oe
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic cond_met(input logic [1:0] cond, input logic [31:0] val,
                                    input logic [31:0] cnt);
    case (acsl_pkg::acsl_cond_t'(cond))
      acsl_pkg::COND_EQ: cond_met = (val == cnt);
      acsl_pkg::COND_GT: cond_met = ($signed(val) > $signed(cnt));
      acsl_pkg::COND_LT: cond_met = ($signed(val) < $signed(cnt));
      default: cond_met = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] ring_step(input logic [31:0] cnt, input logic [31:0] cmp,
                                            input logic ring, input acsl_pkg::acsl_step_t st);
    ring_step = cnt;
    if (st.up && !st.down) begin
      if (ring && cnt == cmp) begin
        ring_step = acsl_pkg::RST_WORD;
      end else begin
        ring_step = cnt + 32'h0000_0001;
      end
    end else if (st.down && !st.up) begin
      if (ring && cnt == acsl_pkg::RST_WORD) begin
        ring_step = cmp;
      end else begin
        ring_step = cnt - 32'h0000_0001;
      end
    end
  endfunction

  function automatic acsl_pkg::acsl_pin_t pin_drive(input logic [1:0] fn, input logic match,
                                                    input logic gpo);
    pin_drive.oe = 1'b1;
    case (acsl_pkg::acsl_pinfn_t'(fn))
      acsl_pkg::PIN_GPOUT: pin_drive.o = gpo;
      acsl_pkg::PIN_MATCH_LO: pin_drive.o = !match;
      acsl_pkg::PIN_MATCH_HI: pin_drive.o = match;
      default: begin
        pin_drive.o = 1'b0;
        pin_drive.oe = 1'b0;
      end
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  acsl_pkg::acsl_state_t state_q;
  acsl_pkg::acsl_state_t state_d;

  logic match_one;
  logic match_two;
  logic over_pos;
  logic under_neg;
  logic [31:0] lim_cnt;
  logic [15:0] msts;
  logic ring_one;
  logic ring_two;
  logic [1:0] lim_mode;
  logic manual_clr;

  // ----------------------------------------------------------------------
  // Comparators, evaluated every cycle
  // ----------------------------------------------------------------------
  assign ring_one = state_q.env3[acsl_pkg::E3_RING_MODE_COUNTER_ONE];
  assign ring_two = state_q.env3[acsl_pkg::E3_RING_MODE_COUNTER_TWO];
  assign match_one = cond_met(state_q.env3[acsl_pkg::E3_C1S +: 2], state_q.cmp1,
                              state_q.cnt1);
  assign match_two = cond_met(state_q.env3[acsl_pkg::E3_C2S +: 2], state_q.cmp2,
                              state_q.cnt2);
  assign lim_cnt = state_q.env3[acsl_pkg::E3_SLCU] ? state_q.cnt2 : state_q.cnt1;
  assign over_pos = $signed(lim_cnt) > $signed(state_q.cmp3);
  assign under_neg = $signed(lim_cnt) < $signed(state_q.cmp4);
  assign lim_mode = state_q.env3[acsl_pkg::E3_SLM +: 2];
  assign manual_clr = state_q.env2[acsl_pkg::E2_MANUAL_CLEAR_SELECT];

  always_comb begin
    msts = 16'h0000;
    msts[acsl_pkg::MS_CP1] = match_one;
    msts[acsl_pkg::MS_CP2] = match_two;
    msts[acsl_pkg::MS_CP3] = over_pos;
    msts[acsl_pkg::MS_CP4] = under_neg;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic do_write;
    logic do_read;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [31:0] ev_set;
    logic [31:0] er_set;
    logic [31:0] ev_clr;
    logic [31:0] er_clr;
    logic pos_rise;
    logic neg_rise;
    logic lim_err;
    state_d = state_q;
    do_write = state_q.aw_full && state_q.w_full && !state_q.bvalid;
    do_read = s_axi_arvalid && !state_q.rvalid;
    wa = state_q.aw_addr;
    ra = 8'(s_axi_araddr);
    ev_set = acsl_pkg::RST_WORD;
    er_set = acsl_pkg::RST_WORD;
    ev_clr = acsl_pkg::RST_WORD;
    er_clr = acsl_pkg::RST_WORD;
    pos_rise = over_pos && !state_q.prev[2];
    neg_rise = under_neg && !state_q.prev[3];
    lim_err = (lim_mode == acsl_pkg::LIM_ERR_NOW) || (lim_mode == acsl_pkg::LIM_ERR_DEC);

    // Rising edges only, so a held condition flags once
    ev_set[acsl_pkg::EV_C1] = match_one && !state_q.prev[0];
    ev_set[acsl_pkg::EV_C2] = match_two && !state_q.prev[1];
    if (lim_mode == acsl_pkg::LIM_EVENT) begin
      ev_set[acsl_pkg::EV_PS] = pos_rise;
      ev_set[acsl_pkg::EV_MS] = neg_rise;
    end
    if (lim_err) begin
      er_set[acsl_pkg::ER_PS] = pos_rise;
      er_set[acsl_pkg::ER_MS] = neg_rise;
    end
    state_d.prev = {under_neg, over_pos, match_two, match_one};

    // Stops come only from error modes; event mode never reaches here
    state_d.stop_now = lim_err && (pos_rise || neg_rise) &&
                       (lim_mode == acsl_pkg::LIM_ERR_NOW || const_speed_start);
    state_d.stop_dec = lim_err && (pos_rise || neg_rise) &&
                       lim_mode == acsl_pkg::LIM_ERR_DEC && !const_speed_start;
    state_d.p3 = pin_drive(state_q.env2[acsl_pkg::E2_P3M +: 2], match_one,
                           state_q.gpo[0]);
    state_d.p4 = pin_drive(state_q.env2[acsl_pkg::E2_P4M +: 2], match_two,
                           state_q.gpo[1]);

    // Counters step; a bus write to a counter overrides the step
    state_d.cnt1 = ring_step(state_q.cnt1, state_q.cmp1, ring_one, step_one);
    state_d.cnt2 = ring_step(state_q.cnt2, state_q.cmp2, ring_two, step_two);

    // AXI write channels
    if (s_axi_awvalid && s_axi_awready) begin
      state_d.aw_full = 1'b1;
      state_d.aw_addr = 8'(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_d.w_full = 1'b1;
      state_d.w_data = s_axi_wdata;
      state_d.w_strb = s_axi_wstrb;
    end
    if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
    end
    if (do_write) begin
      state_d.aw_full = 1'b0;
      state_d.w_full = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = acsl_pkg::RESP_OKAY;
      case (wa)
        acsl_pkg::OFS_ENV2: state_d.env2 = merge(state_q.env2, state_q.w_data, state_q.w_strb);
        acsl_pkg::OFS_ENV3: state_d.env3 = merge(state_q.env3, state_q.w_data, state_q.w_strb);
        acsl_pkg::OFS_IRQEN: begin
          state_d.irqen = merge(state_q.irqen, state_q.w_data, state_q.w_strb);
        end
        acsl_pkg::OFS_EVF: begin
          if (manual_clr) begin
            ev_clr = merge(acsl_pkg::RST_WORD, state_q.w_data, state_q.w_strb);
          end
        end
        acsl_pkg::OFS_ERF: begin
          if (manual_clr) begin
            er_clr = merge(acsl_pkg::RST_WORD, state_q.w_data, state_q.w_strb);
          end
        end
        acsl_pkg::OFS_MSTS: state_d.bresp = acsl_pkg::RESP_OKAY;
        acsl_pkg::OFS_CMP1: state_d.cmp1 = merge(state_q.cmp1, state_q.w_data, state_q.w_strb);
        acsl_pkg::OFS_CMP2: state_d.cmp2 = merge(state_q.cmp2, state_q.w_data, state_q.w_strb);
        acsl_pkg::OFS_CMP3: state_d.cmp3 = merge(state_q.cmp3, state_q.w_data, state_q.w_strb);
        acsl_pkg::OFS_CMP4: state_d.cmp4 = merge(state_q.cmp4, state_q.w_data, state_q.w_strb);
        acsl_pkg::OFS_CNT1: state_d.cnt1 = merge(state_q.cnt1, state_q.w_data, state_q.w_strb);
        acsl_pkg::OFS_CNT2: state_d.cnt2 = merge(state_q.cnt2, state_q.w_data, state_q.w_strb);
        acsl_pkg::OFS_GPIO: begin
          if (state_q.w_strb[0]) begin
            state_d.gpo = state_q.w_data[1:0];
          end
        end
        default: state_d.bresp = acsl_pkg::RESP_SLVERR;
      endcase
    end

    // AXI read channel; reading the flag words clears them unless manual clear is selected
    if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
    end
    if (do_read) begin
      state_d.rvalid = 1'b1;
      state_d.rresp = acsl_pkg::RESP_OKAY;
      case (ra)
        acsl_pkg::OFS_ENV2: state_d.rdata = state_q.env2;
        acsl_pkg::OFS_ENV3: state_d.rdata = state_q.env3;
        acsl_pkg::OFS_IRQEN: state_d.rdata = state_q.irqen;
        acsl_pkg::OFS_EVF: begin
          state_d.rdata = state_q.evf;
          if (!manual_clr) begin
            ev_clr = state_q.evf;
          end
        end
        acsl_pkg::OFS_ERF: begin
          state_d.rdata = state_q.erf;
          if (!manual_clr) begin
            er_clr = state_q.erf;
          end
        end
        acsl_pkg::OFS_MSTS: state_d.rdata = {16'h0000, msts};
        acsl_pkg::OFS_CMP1: state_d.rdata = state_q.cmp1;
        acsl_pkg::OFS_CMP2: state_d.rdata = state_q.cmp2;
        acsl_pkg::OFS_CMP3: state_d.rdata = state_q.cmp3;
        acsl_pkg::OFS_CMP4: state_d.rdata = state_q.cmp4;
        acsl_pkg::OFS_CNT1: state_d.rdata = state_q.cnt1;
        acsl_pkg::OFS_CNT2: state_d.rdata = state_q.cnt2;
        acsl_pkg::OFS_GPIO: begin
          state_d.rdata = {28'h000_0000, pin_four_in, pin_three_in, state_q.gpo};
        end
        default: begin
          state_d.rdata = acsl_pkg::RST_WORD;
          state_d.rresp = acsl_pkg::RESP_SLVERR;
        end
      endcase
    end

    // A new event in the clearing cycle survives
    state_d.evf = (state_q.evf & ~ev_clr) | ev_set;
    state_d.erf = (state_q.erf & ~er_clr) | er_set;
    state_d.irq_n = !(|(state_d.evf & state_d.irqen) || |state_d.erf);
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= '0;
      state_q.irq_n <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = !state_q.aw_full && !state_q.bvalid;
  assign s_axi_wready = !state_q.w_full && !state_q.bvalid;
  assign s_axi_bvalid = state_q.bvalid;
  assign s_axi_bresp = state_q.bresp;
  assign s_axi_arready = !state_q.rvalid;
  assign s_axi_rvalid = state_q.rvalid;
  assign s_axi_rdata = state_q.rdata;
  assign s_axi_rresp = state_q.rresp;
  assign stop_immediate = state_q.stop_now;
  assign stop_decelerate = state_q.stop_dec;
  assign irq_n = state_q.irq_n;
  assign pin_three_out = state_q.p3.o;
  assign pin_three_oe = state_q.p3.oe;
  assign pin_four_out = state_q.p4.o;
  assign pin_four_oe = state_q.p4.oe;

endmodule // acsl_axis_cmp

// file: verilog/acsl_pkg.sv
/*
  Constants, enumerations and carrier types for the per-axis comparator and
  software-limit unit.
  Assumes one 40 MHz clock and an AXI4-Lite register bus of 32-bit words.
*/
package acsl_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_ENV2 = 8'h00;
  localparam logic [7:0] OFS_ENV3 = 8'h04;
  localparam logic [7:0] OFS_IRQEN = 8'h08;
  localparam logic [7:0] OFS_EVF = 8'h0C;
  localparam logic [7:0] OFS_ERF = 8'h10;
  localparam logic [7:0] OFS_MSTS = 8'h14;
  localparam logic [7:0] OFS_CMP1 = 8'h18;
  localparam logic [7:0] OFS_CMP2 = 8'h1C;
  localparam logic [7:0] OFS_CMP3 = 8'h20;
  localparam logic [7:0] OFS_CMP4 = 8'h24;
  localparam logic [7:0] OFS_CNT1 = 8'h28;
  localparam logic [7:0] OFS_CNT2 = 8'h2C;
  localparam logic [7:0] OFS_GPIO = 8'h30;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned E3_RING_MODE_COUNTER_ONE = 7;
  localparam int unsigned E3_RING_MODE_COUNTER_TWO = 11;
  localparam int unsigned E3_C1S = 12;
  localparam int unsigned E3_C2S = 14;
  localparam int unsigned E3_SLM = 22;
  localparam int unsigned E3_SLCU = 24;
  localparam int unsigned E2_P3M = 6;
  localparam int unsigned E2_P4M = 8;
  localparam int unsigned E2_MANUAL_CLEAR_SELECT = 31;
  localparam int unsigned EV_C1 = 6;
  localparam int unsigned EV_C2 = 7;
  localparam int unsigned EV_PS = 14;
  localparam int unsigned EV_MS = 15;
  localparam int unsigned ER_PS = 9;
  localparam int unsigned ER_MS = 10;
  localparam int unsigned MS_CP1 = 8;
  localparam int unsigned MS_CP2 = 9;
  localparam int unsigned MS_CP3 = 10;
  localparam int unsigned MS_CP4 = 11;
  localparam int unsigned GP_IN3 = 2;
  localparam int unsigned GP_IN4 = 3;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    COND_OFF = 2'b00,
    COND_EQ = 2'b01,
    COND_GT = 2'b10,
    COND_LT = 2'b11
  } acsl_cond_t;

  typedef enum logic [1:0] {
    PIN_GPIN = 2'b00,
    PIN_GPOUT = 2'b01,
    PIN_MATCH_LO = 2'b10,
    PIN_MATCH_HI = 2'b11
  } acsl_pinfn_t;

  typedef enum logic [1:0] {
    LIM_NONE = 2'b00,
    LIM_EVENT = 2'b01,
    LIM_ERR_NOW = 2'b10,
    LIM_ERR_DEC = 2'b11
  } acsl_limit_t;

  // ----------------------------------------------------------------------
  // Carriers and block state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic up;
    logic down;
  } acsl_step_t;

  typedef struct packed {
    logic o;
    logic oe;
  } acsl_pin_t;

  typedef struct packed {
    logic [31:0] env2;
    logic [31:0] env3;
    logic [31:0] irqen;
    logic [31:0] evf;
    logic [31:0] erf;
    logic [31:0] cmp1;
    logic [31:0] cmp2;
    logic [31:0] cmp3;
    logic [31:0] cmp4;
    logic [31:0] cnt1;
    logic [31:0] cnt2;
    logic [1:0] gpo;
    logic [3:0] prev;
    logic stop_now;
    logic stop_dec;
    logic irq_n;
    acsl_pin_t p3;
    acsl_pin_t p4;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } acsl_state_t;

endpackage
